//--- verilog/sadc_defines.svh
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Result format
// ----------------------------------------------------------------------------
`define SADC_RESULT_W     12
`define SADC_NIBBLE_W     4
`define SADC_MSB_LO       8
`define SADC_RESULT_RST   12'h000

// ----------------------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------------------
`define SADC_CLK_PERIOD_NS 10
`define SADC_CONV_TIME_NS  3000
`define SADC_CONV_CYCLES \
  ((`SADC_CONV_TIME_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_STEP_CYCLES \
  ((`SADC_CONV_CYCLES + `SADC_RESULT_W - 1) / `SADC_RESULT_W)

`endif

//--- verilog/sadc_pkg.sv
package sadc_pkg;

  // --------------------------------------------------------------------------
  // Conversion engine states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SADC_IDLE = 3'b001,
    SADC_CONV = 3'b010,
    SADC_DONE = 3'b100
  } sadc_state_t;

endpackage : sadc_pkg

//--- verilog/sadc_conv_if.sv
`timescale 1ns/1ns

interface sadc_conv_if #(
  parameter int W = 12
);
  logic         start;
  logic [W-1:0] sample;
  logic         busy;
  logic         done;
  logic [W-1:0] result;

  modport ctrl (output start, output sample, input busy, input done,
                input result);
  modport engine (input start, input sample, output busy, output done,
                  output result);
endinterface : sadc_conv_if

//--- verilog/sadc_sar_core.sv
`timescale 1ns/1ns
`include "sadc_defines.svh"

module sadc_sar_core
  import sadc_pkg::*;
#(
  parameter int W           = `SADC_RESULT_W,
  parameter int STEP_CYCLES = `SADC_STEP_CYCLES
) (
  input wire logic clk,         // System clock.
  input wire logic rst,         // Synchronous reset, active high.
  sadc_conv_if.engine conv      // Start, sample and result handshake.
);

  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam int BW = $clog2(W);

  sadc_state_t   state_q;
  logic [CW-1:0] stepCnt_q;
  logic [BW-1:0] bitIdx_q;
  logic [W-1:0]  hold_q;
  logic [W-1:0]  trial_q;
  logic [W-1:0]  bitMask;

  assign bitMask     = W'(1) << bitIdx_q;
  assign conv.busy   = (state_q != SADC_IDLE);
  assign conv.done   = (state_q == SADC_DONE);
  assign conv.result = trial_q;

  // --------------------------------------------------------------------------
  // Successive approximation, one bit per step of clock cycles.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= SADC_IDLE;
      stepCnt_q <= '0;
      bitIdx_q  <= '0;
      hold_q    <= '0;
      trial_q   <= '0;
    end else begin
      unique case (state_q)
        SADC_IDLE: begin
          if (conv.start) begin
            hold_q    <= conv.sample;
            trial_q   <= '0;
            bitIdx_q  <= BW'(W - 1);
            stepCnt_q <= '0;
            state_q   <= SADC_CONV;
          end
        end
        SADC_CONV: begin
          if (stepCnt_q == CW'(STEP_CYCLES - 1)) begin
            stepCnt_q <= '0;
            if ((trial_q | bitMask) <= hold_q) begin
              trial_q <= trial_q | bitMask;
            end
            if (bitIdx_q == '0) begin
              state_q <= SADC_DONE;
            end else begin
              bitIdx_q <= bitIdx_q - BW'(1);
            end
          end else begin
            stepCnt_q <= stepCnt_q + CW'(1);
          end
        end
        SADC_DONE: begin
          state_q <= SADC_IDLE;
        end
        default: begin
          state_q <= SADC_IDLE;
        end
      endcase
    end
  end

endmodule : sadc_sar_core

//--- verilog/sadc_read_port.sv
// How it works
// - A start needs byte select, chip select and read all low together.
// - Start conditions are ignored while a conversion runs.
// - Busy is low for the whole conversion and two cycles after it, high otherwise.
// - In wait-state use a start drops busy and the held read returns the new result.
// - At conversion end new data reaches the lines before busy rises.
// - Results are right justified, lowest bit on the lowest data line.
// - High byte select gives the top nibble over zeros, low gives all bits.
// - The top four result bits always drive the top four lines.
// - Data lines are driven only while chip select and read are both low.
// - After a wait-state low byte, a high byte read starts nothing.
// - In previous-result use a read returns the old result and starts anew.
// - In previous-result use the next read returns the fresh result.
// - After a conversion, a high byte read starts nothing, a low one does.
`timescale 1ns/1ns
`include "sadc_defines.svh"

module sadc_read_port
  import sadc_pkg::*;
#(
  parameter int W           = `SADC_RESULT_W,
  parameter int STEP_CYCLES = `SADC_STEP_CYCLES
) (
  input  wire logic         clk,            // System clock, 100 MHz.
  input  wire logic         rst,            // Synchronous reset.
  input  wire logic         chipSelN,       // Chip select pin.
  input  wire logic         readStrobeN,    // Read strobe pin.
  input  wire logic         byteSelectHigh, // Byte select pin.
  input  wire logic [W-1:0] sampleCode,     // Quantiser code to convert.
  output logic              busyN,          // Conversion in progress.
  output logic [W-1:0]      dataOutPins,    // Result data lines.
  output logic              dataOeN         // Data drive enable.
);

  // The conversion length must also fit the cycle counter of the checks.
  if (W != `SADC_RESULT_W) begin : gen_width_check
    $error("sadc_read_port: byte multiplexer serves W of 12 only");
  end
  if (STEP_CYCLES < 1 || W * STEP_CYCLES > 32'h0000FFFF) begin : gen_step_check
    $error("sadc_read_port: STEP_CYCLES out of range");
  end

  localparam int NB = `SADC_NIBBLE_W;
  localparam int ML = `SADC_MSB_LO;
  localparam int CL = W * STEP_CYCLES;

  // --------------------------------------------------------------------------
  // Pin synchronisers: chip select, read, byte select.
  // --------------------------------------------------------------------------
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic       csS;
  logic       rdS;
  logic       hbS;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_q <= 3'h7;
      pinSync_q <= 3'h7;
    end else begin
      pinMeta_q <= {byteSelectHigh, readStrobeN, chipSelN};
      pinSync_q <= pinMeta_q;
    end
  end

  assign csS = pinSync_q[0];
  assign rdS = pinSync_q[1];
  assign hbS = pinSync_q[2];

  // --------------------------------------------------------------------------
  // Conversion start.
  // --------------------------------------------------------------------------
  sadc_conv_if #(.W(W)) convIf ();

  logic readActive;
  logic startCond;
  logic startPrev_q;
  logic convBusy;
  logic [1:0] busyHold_q;

  assign readActive = !csS && !rdS;
  assign startCond  = readActive && !hbS;
  assign convBusy   = convIf.busy || busyHold_q != '0;

  // The start request is an edge of the combined condition, so a read held
  // low across the end of a conversion does not launch another one.
  assign convIf.start  = startCond && !startPrev_q && !convBusy;
  assign convIf.sample = sampleCode;

  always_ff @(posedge clk) begin
    if (rst) begin
      startPrev_q <= 1'b0;
    end else begin
      startPrev_q <= startCond;
    end
  end

  sadc_sar_core #(
    .W           (W),
    .STEP_CYCLES (STEP_CYCLES)
  ) u_core (
    .clk  (clk),
    .rst  (rst),
    .conv (convIf.engine)
  );

  // --------------------------------------------------------------------------
  // Result latch and busy sequencing.
  // --------------------------------------------------------------------------
  logic [W-1:0] latch_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= `SADC_RESULT_RST;
    end else if (convIf.done) begin
      latch_q <= convIf.result;
    end
  end

  // Busy stays low two cycles past the engine so the new result is on the
  // data lines before busy rises.
  always_ff @(posedge clk) begin
    if (rst) begin
      busyHold_q <= 2'h0;
    end else begin
      busyHold_q <= {busyHold_q[0], convIf.done};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busyN <= 1'b1;
    end else begin
      busyN <= !convBusy;
    end
  end

  // --------------------------------------------------------------------------
  // Output multiplexer and drive enable.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dataOutPins <= `SADC_RESULT_RST;
    end else if (hbS) begin
      dataOutPins <= {latch_q[W-1:ML], {NB{1'b0}},
                      latch_q[W-1:ML]};
    end else begin
      dataOutPins <= latch_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dataOeN <= 1'b1;
    end else begin
      dataOeN <= !readActive;
    end
  end

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  start_gate_a: assert property ($rose(convIf.busy) |->
    $past(!csS && !rdS && !hbS))
    else $error("conversion began without all three inputs low");

  no_restart_a: assert property (convIf.busy |->
    !convIf.start)
    else $error("start accepted during a conversion");

  busy_ack_a: assert property (convIf.start |->
    ##2 !busyN)
    else $error("busy did not fall two cycles after start");

  busy_hold_a: assert property ($fell(busyN) |->
    !busyN [*8])
    else $error("busy rose too early in a conversion");

  busy_idle_a: assert property (!convIf.busy && busyHold_q == 2'h0
    && $past(!convIf.busy) |=> busyN)
    else $error("busy low with no conversion");

  done_order_a: assert property (convIf.done |->
    ##1 (latch_q == $past(convIf.result)) ##3 $rose(busyN))
    else $error("busy rose out of order with latch update");

  msb_always_a: assert property (!dataOeN |->
    dataOutPins[W-1:ML] == $past(latch_q[W-1:ML]))
    else $error("top nibble not on top data lines");

  byte_high_a: assert property (!dataOeN && $past(hbS) |->
    dataOutPins[ML-1:0] == {{NB{1'b0}}, $past(latch_q[W-1:ML])})
    else $error("high byte not placed on low lines");

  word_low_a: assert property (!dataOeN && !$past(hbS) |->
    dataOutPins == $past(latch_q))
    else $error("full word not right justified");

  oe_gate_a: assert property (!dataOeN |->
    $past(readActive))
    else $error("data driven without chip select and read");

  hb_nostart_a: assert property (hbS |->
    !convIf.start)
    else $error("high byte read started a conversion");

  prev_result_a: assert property (convIf.start |->
    ##1 latch_q == $past(latch_q))
    else $error("start disturbed the previous result");

  // Cycles spent converting, held against the fixed conversion length.
  logic [15:0] convCycles_q;

  always_ff @(posedge clk) begin
    if (rst || convIf.start) begin
      convCycles_q <= 16'h0000;
    end else if (convIf.busy) begin
      convCycles_q <= convCycles_q + 16'h0001;
    end
  end

  conv_length_a: assert property (convIf.done |->
    convCycles_q == 16'(CL))
    else $error("conversion length differs from its fixed count");

endmodule : sadc_read_port

//--- bench/sadc_host_model.sv
`timescale 1ns/1ns

module sadc_host_model (
  input  wire logic        clk,            // System clock.
  input  wire logic        busyN,          // Device busy, active low.
  input  wire logic [11:0] dataOutPins,    // Device data lines.
  input  wire logic        dataOeN,        // Device drive enable.
  output logic             chipSelN,       // Chip select to device.
  output logic             readStrobeN,    // Read strobe to device.
  output logic             byteSelectHigh  // Byte select to device.
);
  // --------------------------------------------------------------------------
  // Read cycle
  // --------------------------------------------------------------------------
  initial begin
    chipSelN       = 1'b1;
    readStrobeN    = 1'b1;
    byteSelectHigh = 1'b0;
  end

  // A stalled read is held until busy returns high, a quick one takes data
  // after six cycles; undriven lines come back as unknown so they never match.
  task automatic hostRead(input logic hb, input bit stall,
                          output logic [11:0] data, output logic sawBusy);
    int n;
    @(posedge clk);
    #1;
    byteSelectHigh = hb;
    chipSelN       = 1'b0;
    readStrobeN    = 1'b0;
    sawBusy        = 1'b0;
    n              = 0;
    repeat (6) begin
      @(posedge clk);
      if (busyN === 1'b0) sawBusy = 1'b1;
    end
    while (stall && busyN !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    data = (dataOeN === 1'b0 && n < 400) ? dataOutPins : 12'hXXX;
    #1;
    chipSelN       = 1'b1;
    readStrobeN    = 1'b1;
    byteSelectHigh = 1'b0;
  endtask : hostRead
endmodule : sadc_host_model

//--- bench/tb_sampling_adc_host_read_port.sv
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin \
  miscompares++; $display("Error %s expected %h seen %h", nm, exp, got); \
  end end

module tb_sampling_adc_host_read_port;
  localparam int STEP     = 2;
  localparam int BUSY_LOW = 12 * STEP + 3;

  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic [11:0] sampleCode = 12'h000;
  logic        chipSelN;
  logic        readStrobeN;
  logic        byteSelectHigh;
  logic        busyN;
  logic        dataOeN;
  logic [11:0] dataOutPins;
  logic [11:0] got;
  logic        sawBusy;
  int          miscompares = 0;
  int          cmpCount    = 0;
  int          lowCnt      = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (busyN === 1'b0) lowCnt <= lowCnt + 1;

  sadc_read_port #(.W(12), .STEP_CYCLES(STEP)) dut (
    .clk(clk), .rst(rst), .chipSelN(chipSelN), .readStrobeN(readStrobeN),
    .byteSelectHigh(byteSelectHigh), .sampleCode(sampleCode),
    .busyN(busyN), .dataOutPins(dataOutPins), .dataOeN(dataOeN));

  sadc_host_model host (
    .clk(clk), .busyN(busyN), .dataOutPins(dataOutPins), .dataOeN(dataOeN),
    .chipSelN(chipSelN), .readStrobeN(readStrobeN),
    .byteSelectHigh(byteSelectHigh));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic results;
    $display("Comparisons %0d, miscompares %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic setCode(input logic [11:0] c);
    @(posedge clk);
    #1;
    sampleCode = c;
  endtask : setCode

  // One read, then release checks and the spacing before the next start.
  task automatic rdChk(input string nm, input logic hb, input bit stall,
                       input logic [11:0] exp, input logic expBusy);
    host.hostRead(hb, stall, got, sawBusy);
    `CHK(nm, exp, got)
    `CHK("busy seen", expBusy, sawBusy)
    repeat (4) @(posedge clk);
    `CHK("drive off", 1'b1, dataOeN)
    repeat (130) @(posedge clk);
  endtask : rdChk

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic tWaitMode;
    setCode(12'hA5C);
    lowCnt = 0;
    rdChk("wait word", 1'b0, 1'b1, 12'hA5C, 1'b1);
    `CHK("busy length", BUSY_LOW, lowCnt)
    setCode(12'h3B7);
    rdChk("wait low", 1'b0, 1'b1, 12'h3B7, 1'b1);
    rdChk("wait high", 1'b1, 1'b0, 12'h303, 1'b0);
  endtask : tWaitMode

  task automatic tPrevMode;
    setCode(12'hC41);
    rdChk("prev old", 1'b0, 1'b0, 12'h3B7, 1'b1);
    setCode(12'h96E);
    rdChk("prev new", 1'b0, 1'b0, 12'hC41, 1'b1);
    setCode(12'h1F0);
    rdChk("prev high", 1'b1, 1'b0, 12'h909, 1'b0);
    rdChk("prev low", 1'b0, 1'b0, 12'h96E, 1'b1);
  endtask : tPrevMode

  task automatic tBusyIgnore;
    setCode(12'h5A2);
    host.hostRead(1'b0, 1'b0, got, sawBusy);
    `CHK("first start", 12'h1F0, got)
    setCode(12'h0FF);
    host.hostRead(1'b0, 1'b0, got, sawBusy);
    `CHK("read in busy", 12'h1F0, got)
    repeat (130) @(posedge clk);
    rdChk("no restart", 1'b0, 1'b0, 12'h5A2, 1'b1);
  endtask : tBusyIgnore

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    `CHK("idle busy", 1'b1, busyN)
    `CHK("idle drive", 1'b1, dataOeN)
    tWaitMode();
    tPrevMode();
    tBusyIgnore();
    results();
  end

  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule : tb_sampling_adc_host_read_port
